// ===== inc/lcg_map.svh
// Register indices, field positions, reset values and timing counts
`ifndef LCG_MAP_SVH
`define LCG_MAP_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define LCG_IDX_TGT_MAX  8'h35
`define LCG_IDX_GAIN_LIM 8'h37
`define LCG_IDX_CLIP     8'h38
`define LCG_IDX_MODE     8'h39
`define LCG_IDX_STATUS   8'h3a
`define LCG_IDX_CAL      8'h44
`define LCG_IDX_L_MID    8'h45
`define LCG_IDX_L_UP     8'h46
`define LCG_IDX_R_MID    8'h47
`define LCG_IDX_R_UP     8'h48

// ==========================================================================
// Field positions
`define LCG_CEIL_MSB     6
`define LCG_CEIL_LSB     4
`define LCG_FLOOR_MSB    2
`define LCG_FLOOR_LSB    0
`define LCG_TGT_MSB      5
`define LCG_CLIP_EN_BIT  7
`define LCG_STEP_MSB     1
`define LCG_HYBRID_BIT   0
`define LCG_OFS_EN_BIT   0
`define LCG_AUTO_BIT     2
`define LCG_OVF_BIT      3

// ==========================================================================
// Reset values
`define LCG_CEIL_RST     3'h7
`define LCG_FLOOR_RST    3'h1
`define LCG_TGT_RST      6'h00
`define LCG_STEP_RST     2'h0

// ==========================================================================
// Timing: system clock, sample rate, calibration length
`define LCG_CLK_HZ       25000000
`define LCG_FS_HZ        48000
`define LCG_FS_DIV       (`LCG_CLK_HZ / `LCG_FS_HZ)
`define LCG_CAL_LOG2     4

`endif

// ===== inc/lcg_pkg.sv
// Types shared by the level control register block
package lcg_pkg;

  typedef struct packed {
    logic [2:0] ceil;
    logic [2:0] floor;
  } lcg_limits_t;

  typedef struct packed {
    logic       en;
    logic [1:0] step;
  } lcg_clip_t;

  typedef struct packed {
    logic ovf;
    logic auto_run;
    logic ofs_en;
  } lcg_cal_t;

  typedef struct packed {
    logic [19:0] left;
    logic [19:0] right;
  } lcg_pair_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       hit;
    logic [7:0] idx;
    logic [7:0] data;
  } lcg_req_t;

  typedef enum logic [2:0] {
    LCG_IDLE = 3'b001,
    LCG_ACC  = 3'b010,
    LCG_DONE = 3'b100
  } lcg_cal_state_t;

endpackage

// ===== rtl/lcg_wb_slave.sv
// Classic Wishbone slave front end with one-cycle registered answer
`timescale 1ns/100ps
module lcg_wb_slave (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [31:0]      wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic [7:0]       rdata_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  output lcg_pkg::lcg_req_t     req_o
);

  logic take;

  assign take       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign req_o.wr   = take & wb_we_i & wb_sel_i[0];
  assign req_o.rd   = take & ~wb_we_i;
  assign req_o.hit  = (wb_adr_i[31:10] == 22'h000000);
  assign req_o.idx  = wb_adr_i[9:2];
  assign req_o.data = wb_dat_i[7:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= take;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (take) begin
      wb_dat_o <= {24'h000000, rdata_i};
    end
  end

endmodule

// ===== rtl/lcg_offset_cal.sv
// Automatic DC offset calibration: averages samples, yields correction
`timescale 1ns/100ps
`include "lcg_map.svh"
module lcg_offset_cal #(
  parameter int CAL_LOG2 = `LCG_CAL_LOG2
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              start_i,
  input  wire logic              sample_en_i,
  input  wire logic [19:0]       left_i,
  input  wire logic [19:0]       right_i,
  output logic                   done_o,
  output logic                   ovf_o,
  output lcg_pkg::lcg_pair_t     result_o
);

  localparam int SW = 20 + CAL_LOG2;

  lcg_pkg::lcg_cal_state_t state_reg;
  logic [SW-1:0]           sum_l_reg;
  logic [SW-1:0]           sum_r_reg;
  logic [CAL_LOG2-1:0]     cnt_reg;
  logic [20:0]             corr_l;
  logic [20:0]             corr_r;

  // Negated average; top bit flags a value that cannot be negated
  function automatic logic [20:0] correction(input logic [SW-1:0] sum);
    logic [19:0] avg;
    avg = sum[SW-1:CAL_LOG2];
    correction = {avg == 20'h80000, 20'(-avg)};
  endfunction

  assign corr_l = correction(sum_l_reg);
  assign corr_r = correction(sum_r_reg);

  // ========================================================================
  // Sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= lcg_pkg::LCG_IDLE;
    end else begin
      unique case (state_reg)
        lcg_pkg::LCG_IDLE: begin
          if (start_i) state_reg <= lcg_pkg::LCG_ACC;
        end
        lcg_pkg::LCG_ACC: begin
          if (sample_en_i && cnt_reg == {CAL_LOG2{1'b1}}) state_reg <= lcg_pkg::LCG_DONE;
        end
        lcg_pkg::LCG_DONE: begin
          state_reg <= start_i ? lcg_pkg::LCG_ACC : lcg_pkg::LCG_IDLE;
        end
        default: state_reg <= lcg_pkg::LCG_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Accumulators
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg != lcg_pkg::LCG_ACC) begin
      sum_l_reg <= '0;
      sum_r_reg <= '0;
      cnt_reg   <= '0;
    end else if (sample_en_i) begin
      sum_l_reg <= sum_l_reg + SW'({{CAL_LOG2{left_i[19]}}, left_i});
      sum_r_reg <= sum_r_reg + SW'({{CAL_LOG2{right_i[19]}}, right_i});
      cnt_reg   <= cnt_reg + 1'b1;
    end
  end

  // ========================================================================
  // Results held until the next completion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_o <= '0;
      ovf_o    <= 1'b0;
      done_o   <= 1'b0;
    end else begin
      done_o <= (state_reg == lcg_pkg::LCG_DONE);
      if (state_reg == lcg_pkg::LCG_DONE) begin
        result_o.left  <= corr_l[19:0];
        result_o.right <= corr_r[19:0];
        ovf_o          <= corr_l[20] | corr_r[20];
      end
    end
  end

endmodule

// ===== rtl/lcg_top.sv
// Level control limits, clip guard and offset calibration register block
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/100ps
`include "lcg_map.svh"
module lcg_top #(
  parameter int FS_DIV   = `LCG_FS_DIV,
  parameter int CAL_LOG2 = `LCG_CAL_LOG2,
  parameter int ATTEN_W  = 12
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [31:0]         wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic                wb_we_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [2:0]          gain_req_i,
  input  wire logic [5:0]          out_level_i,
  input  wire logic [19:0]         adc_left_i,
  input  wire logic [19:0]         adc_right_i,
  output logic [2:0]               analog_gain_o,
  output logic                     over_target_o,
  output logic [ATTEN_W-1:0]       clip_atten_o,
  output logic                     sample_en_o,
  output logic                     offset_en_o,
  output logic [19:0]              offset_left_o,
  output logic [19:0]              offset_right_o
);

  // ========================================================================
  // Declarations
  lcg_pkg::lcg_req_t       req;
  lcg_pkg::lcg_limits_t    limits_reg;
  lcg_pkg::lcg_clip_t      clip_reg;
  lcg_pkg::lcg_cal_t       cal_reg;
  lcg_pkg::lcg_pair_t      cal_result;
  logic [5:0]              tgt_reg;
  logic                    hybrid_reg;
  logic [15:0]             div_reg;
  logic                    sample_en;
  logic                    cal_start;
  logic                    cal_done;
  logic                    cal_ovf;
  logic                    over_next;
  logic [ATTEN_W-1:0]      step_next;
  logic [7:0]              rdata;

  localparam logic [ATTEN_W-1:0] ATTEN_MAX = {ATTEN_W{1'b1}};
  localparam logic [15:0]        DIV_LAST  = 16'(FS_DIV - 1);

  // Clamp requested analog gain between floor and ceiling
  function automatic logic [2:0] clamp_gain(input logic [2:0] req_code,
                                            input logic [2:0] lo,
                                            input logic [2:0] hi);
    // Floor first, so the ceiling wins when the two cross
    clamp_gain = (req_code < lo) ? lo : req_code;
    if (clamp_gain > hi) begin
      clamp_gain = hi;
    end
  endfunction

  // True when the register bus write hits a given index
  function automatic logic wr_hit(input lcg_pkg::lcg_req_t r, input logic [7:0] idx);
    wr_hit = r.wr & r.hit & (r.idx == idx);
  endfunction

  // ========================================================================
  // Bus front end
  lcg_wb_slave u_bus (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_i (wb_dat_i),
    .wb_we_i  (wb_we_i),
    .wb_sel_i (wb_sel_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .rdata_i  (rdata),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .req_o    (req)
  );

  // ========================================================================
  // Sample rate enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg   <= 16'h0000;
      sample_en <= 1'b0;
    end else begin
      sample_en <= (div_reg == DIV_LAST);
      div_reg   <= (div_reg == DIV_LAST) ? 16'h0000 : div_reg + 16'h0001;
    end
  end

  // ========================================================================
  // Analog gain limits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limits_reg.ceil  <= `LCG_CEIL_RST;
      limits_reg.floor <= `LCG_FLOOR_RST;
    end else if (wr_hit(req, `LCG_IDX_GAIN_LIM)) begin
      limits_reg.ceil  <= req.data[`LCG_CEIL_MSB:`LCG_CEIL_LSB];
      limits_reg.floor <= req.data[`LCG_FLOOR_MSB:`LCG_FLOOR_LSB];
    end
  end

  // Hybrid gain mode select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hybrid_reg <= 1'b0;
    end else if (wr_hit(req, `LCG_IDX_MODE)) begin
      hybrid_reg <= req.data[`LCG_HYBRID_BIT];
    end
  end

  // Limits only act in hybrid mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_gain_o <= 3'h0;
    end else if (hybrid_reg) begin
      analog_gain_o <= clamp_gain(gain_req_i, limits_reg.floor, limits_reg.ceil);
    end else begin
      analog_gain_o <= gain_req_i;
    end
  end

  // ========================================================================
  // Upper target and clip guard
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tgt_reg <= `LCG_TGT_RST;
    end else if (wr_hit(req, `LCG_IDX_TGT_MAX)) begin
      tgt_reg <= req.data[`LCG_TGT_MSB:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clip_reg.en   <= 1'b0;
      clip_reg.step <= `LCG_STEP_RST;
    end else if (wr_hit(req, `LCG_IDX_CLIP)) begin
      clip_reg.en   <= req.data[`LCG_CLIP_EN_BIT];
      clip_reg.step <= req.data[`LCG_STEP_MSB:0];
    end
  end

  // Smaller level code is louder, so louder than target means below it
  assign over_next = (out_level_i < tgt_reg);
  // One unit is 0.034 dB; each step code doubles it
  assign step_next = ATTEN_W'(1) << clip_reg.step;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      over_target_o <= 1'b0;
    end else begin
      over_target_o <= over_next;
    end
  end

  // Attenuation grows once per sample while above target
  always_ff @(posedge clk_i) begin
    if (rst_i || !clip_reg.en) begin
      clip_atten_o <= '0;
    end else if (sample_en && over_next) begin
      if (clip_atten_o > ATTEN_MAX - step_next) begin
        clip_atten_o <= ATTEN_MAX;
      end else begin
        clip_atten_o <= clip_atten_o + step_next;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_en_o <= 1'b0;
    end else begin
      sample_en_o <= sample_en;
    end
  end

  // ========================================================================
  // Offset calibration control
  // A start is accepted while idle, or in the very cycle the run ends
  assign cal_start = wr_hit(req, `LCG_IDX_CAL) & req.data[`LCG_AUTO_BIT]
                   & (~cal_reg.auto_run | cal_done);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_reg.ofs_en <= 1'b0;
    end else if (wr_hit(req, `LCG_IDX_CAL)) begin
      cal_reg.ofs_en <= req.data[`LCG_OFS_EN_BIT];
    end
  end

  // Set by software, cleared on completion; a new start wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_reg.auto_run <= 1'b0;
    end else if (cal_start) begin
      cal_reg.auto_run <= 1'b1;
    end else if (cal_done) begin
      cal_reg.auto_run <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_reg.ovf <= 1'b0;
    end else if (cal_done) begin
      cal_reg.ovf <= cal_ovf;
    end
  end

  lcg_offset_cal #(
    .CAL_LOG2 (CAL_LOG2)
  ) u_cal (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .start_i     (cal_start),
    .sample_en_i (sample_en),
    .left_i      (adc_left_i),
    .right_i     (adc_right_i),
    .done_o      (cal_done),
    .ovf_o       (cal_ovf),
    .result_o    (cal_result)
  );

  // Correction applied only while cancellation is enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      offset_en_o    <= 1'b0;
      offset_left_o  <= 20'h00000;
      offset_right_o <= 20'h00000;
    end else begin
      offset_en_o    <= cal_reg.ofs_en;
      offset_left_o  <= cal_reg.ofs_en ? cal_result.left : 20'h00000;
      offset_right_o <= cal_reg.ofs_en ? cal_result.right : 20'h00000;
    end
  end

  // ========================================================================
  // Read multiplexer
  always_comb begin
    rdata = 8'h00;
    if (req.hit) begin
      unique case (req.idx)
        `LCG_IDX_TGT_MAX:  rdata = {2'b00, tgt_reg};
        `LCG_IDX_GAIN_LIM: rdata = {1'b0, limits_reg.ceil, 1'b0, limits_reg.floor};
        `LCG_IDX_CLIP:     rdata = {clip_reg.en, 5'h00, clip_reg.step};
        `LCG_IDX_MODE:     rdata = {7'h00, hybrid_reg};
        `LCG_IDX_STATUS:   rdata = {3'h0, clip_atten_o != '0, over_target_o,
                                    analog_gain_o};
        `LCG_IDX_CAL:      rdata = {4'h0, cal_reg.ovf, cal_reg.auto_run,
                                    1'b0, cal_reg.ofs_en};
        `LCG_IDX_L_MID:    rdata = cal_result.left[15:8];
        `LCG_IDX_L_UP:     rdata = {4'h0, cal_result.left[19:16]};
        `LCG_IDX_R_MID:    rdata = cal_result.right[15:8];
        `LCG_IDX_R_UP:     rdata = {4'h0, cal_result.right[19:16]};
        default:           rdata = 8'h00;
      endcase
    end
  end

endmodule

// ===== tb/lcg_top_assertions.sv
// Concurrent checks on the ports of the level control register block
`timescale 1ns/100ps
module lcg_top_chk #(
  parameter int FS_DIV   = 4,
  parameter int CAL_LOG2 = 4,
  parameter int ATTEN_W  = 12
) (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic [31:0]        wb_adr_i,
  input wire logic [31:0]        wb_dat_i,
  input wire logic               wb_we_i,
  input wire logic [3:0]         wb_sel_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  input wire logic [2:0]         gain_req_i,
  input wire logic [5:0]         out_level_i,
  input wire logic [2:0]         analog_gain_o,
  input wire logic               over_target_o,
  input wire logic [ATTEN_W-1:0] clip_atten_o,
  input wire logic               offset_en_o,
  input wire logic [19:0]        offset_left_o,
  input wire logic [19:0]        offset_right_o
);
  localparam int CAL_LIM = ((2 ** CAL_LOG2) + 2) * FS_DIV + 8;
  logic        take;
  logic        wr;
  logic        rd_ack;
  logic        res_ok;
  logic [7:0]  idx;
  logic [7:0]  rd_idx_reg;
  logic [7:0]  lim_reg;
  logic [7:0]  tgt_reg;
  logic [7:0]  clip_reg;
  logic        mode_reg;
  logic        cal_en_reg;
  logic [1:0]  en_age_reg;
  logic [2:0]  step_age_reg;
  logic [15:0] cal_age_reg;
  logic [2:0]  lo_g;
  logic [2:0]  gain_exp;
  logic        over_exp;

  // ==========================================================================
  // Shadow of the writable fields
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx = (wb_adr_i[31:10] == 22'h0) ? wb_adr_i[9:2] : 8'hff;
  assign wr = take && wb_we_i && wb_sel_i[0];
  assign rd_ack = wb_ack_o && !wb_we_i;
  assign res_ok = cal_en_reg && en_age_reg == 2'h3 && cal_age_reg == 16'(CAL_LIM);
  assign lo_g = (gain_req_i < lim_reg[2:0]) ? lim_reg[2:0] : gain_req_i;
  assign gain_exp = !mode_reg ? gain_req_i : (lo_g > lim_reg[6:4]) ? lim_reg[6:4] : lo_g;
  assign over_exp = out_level_i < tgt_reg[5:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lim_reg <= 8'h71;
      tgt_reg <= 8'h00;
      clip_reg <= 8'h00;
      mode_reg <= 1'b0;
      cal_en_reg <= 1'b0;
    end else if (wr) begin
      if (idx == 8'h37) lim_reg <= wb_dat_i[7:0] & 8'h77;
      if (idx == 8'h35) tgt_reg <= wb_dat_i[7:0] & 8'h3f;
      if (idx == 8'h38) clip_reg <= wb_dat_i[7:0] & 8'h83;
      if (idx == 8'h39) mode_reg <= wb_dat_i[0];
      if (idx == 8'h44) cal_en_reg <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (take) rd_idx_reg <= idx;
  end

  // ==========================================================================
  // Settling counters since the last relevant write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_age_reg <= 2'h0;
      step_age_reg <= 3'h0;
      cal_age_reg <= 16'(CAL_LIM);
    end else begin
      if (wr && idx == 8'h44 && wb_dat_i[0] != cal_en_reg) en_age_reg <= 2'h0;
      else if (en_age_reg != 2'h3) en_age_reg <= en_age_reg + 2'h1;
      if (wr && idx == 8'h38) step_age_reg <= 3'h0;
      else if (step_age_reg != 3'h7) step_age_reg <= step_age_reg + 3'h1;
      if (wr && idx == 8'h44 && wb_dat_i[2]) cal_age_reg <= 16'h0;
      else if (cal_age_reg < 16'(CAL_LIM)) cal_age_reg <= cal_age_reg + 16'h1;
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  limits_readback_a: assert property (
    rd_ack && rd_idx_reg == 8'h37 |-> wb_dat_o == {24'h0, lim_reg})
    else $error("gain limits read back wrong");
  gain_clamp_a: assert property (
    !$past(rst_i) |-> analog_gain_o == $past(gain_exp))
    else $error("analog gain not limited as set");
  over_target_a: assert property (
    !$past(rst_i) |-> over_target_o == $past(over_exp))
    else $error("over target flag wrong");
  clip_off_a: assert property (
    !clip_reg[7] && step_age_reg == 3'h7 |-> clip_atten_o == '0)
    else $error("attenuation while clip guard off");
  clip_step_a: assert property (
    clip_reg[7] && step_age_reg == 3'h7 && clip_atten_o > $past(clip_atten_o) |->
      (clip_atten_o - $past(clip_atten_o) == (ATTEN_W'(1) << clip_reg[1:0])) || &clip_atten_o)
    else $error("attenuation step wrong");
  offset_copy_a: assert property (
    !$past(rst_i) |-> offset_en_o == $past(cal_en_reg))
    else $error("offset enable output wrong");
  offset_off_a: assert property (
    !cal_en_reg && en_age_reg == 2'h3 |-> offset_left_o == 20'h0 && offset_right_o == 20'h0)
    else $error("correction applied while disabled");
  offset_hold_a: assert property (
    cal_age_reg == 16'(CAL_LIM) && en_age_reg == 2'h3 && !$past(rst_i) |->
      $stable(offset_left_o) && $stable(offset_right_o))
    else $error("correction changed without calibration");
  auto_clear_a: assert property (
    rd_ack && rd_idx_reg == 8'h44 && cal_age_reg == 16'(CAL_LIM) |-> !wb_dat_o[2])
    else $error("calibration start bit did not clear");
  left_mid_a: assert property (
    rd_ack && rd_idx_reg == 8'h45 && res_ok |-> wb_dat_o == {24'h0, offset_left_o[15:8]})
    else $error("left middle byte wrong");
  left_up_a: assert property (
    rd_ack && rd_idx_reg == 8'h46 && res_ok |-> wb_dat_o == {28'h0, offset_left_o[19:16]})
    else $error("left upper nibble wrong");
endmodule

bind lcg_top lcg_top_chk #(.FS_DIV(FS_DIV), .CAL_LOG2(CAL_LOG2), .ATTEN_W(ATTEN_W)) i_lcg_top_chk (
  .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .gain_req_i, .out_level_i, .analog_gain_o, .over_target_o, .clip_atten_o,
  .offset_en_o, .offset_left_o, .offset_right_o);

// ===== tb/testbench.sv
// Self-checking testbench for the level control register block
`timescale 1ns/100ps
module testbench;
  localparam int FSD = 4;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [31:0] wb_adr_i = 32'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [2:0]  gain_req_i = 3'h0;
  logic [5:0]  out_level_i = 6'h3f;
  logic [19:0] adc_left_i = 20'h0;
  logic [19:0] adc_right_i = 20'h0;
  logic [2:0]  analog_gain_o;
  logic        over_target_o;
  logic [11:0] clip_atten_o;
  logic        sample_en_o;
  logic        offset_en_o;
  logic [19:0] offset_left_o;
  logic [19:0] offset_right_o;
  int          num_errors = 0;
  int          checks = 0;
  int          m;
  int          g;
  int          s;
  logic [2:0]  e;
  logic [11:0] a0;
  logic [19:0] lc;
  logic [19:0] rc;
  logic [31:0] r;
  logic [31:0] seed = 32'h0001228f;
  logic [31:0] exp_q[$];
  logic [7:0]  rst_idx[7] = '{8'h37, 8'h38, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48};

  always #20 clk_i = ~clk_i;

  lcg_top #(.FS_DIV(FSD), .CAL_LOG2(4), .ATTEN_W(12)) i_lcg_top (
    .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .gain_req_i, .out_level_i, .adc_left_i, .adc_right_i,
    .analog_gain_o, .over_target_o, .clip_atten_o, .sample_en_o, .offset_en_o,
    .offset_left_o, .offset_right_o);

  // ==========================================================================
  // Helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function logic [31:0] a(input logic [7:0] i);
    return {22'h0, i, 2'h0};
  endfunction

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task cyc(input logic [31:0] adr, input logic we, input logic [7:0] d, input logic [3:0] sel);
    logic [31:0] rv;
    rv = rnd();
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= {rv[31:8], d};
    wb_sel_i <= sel;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task wr(input logic [31:0] adr, input logic [7:0] d);
    cyc(adr, 1'b1, d, 4'hf);
  endtask

  task rd(input logic [31:0] adr, input logic [7:0] x);
    exp_q.push_back({24'h0, x});
    cyc(adr, 1'b0, 8'h00, 4'hf);
  endtask

  // Read data checker: oldest expectation against each read answer
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() > 0) cmp(wb_dat_o, exp_q.pop_front());
      else begin
        num_errors++;
        $display("wrong value at %0t: unexpected read answer", $time);
      end
    end
  end

  task conclude();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    tick(5000);
    num_errors++;
    conclude();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    tick(2);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) rd(a(rst_idx[i]), (i == 0) ? 8'h71 : 8'h00);
    $display("test reset values done");
    for (m = 0; m < 3; m++) begin
      wr(a(8'h37), (m == 2) ? 8'h44 : 8'h32);
      rd(a(8'h37), (m == 2) ? 8'h44 : 8'h32);
      wr(a(8'h39), (m == 0) ? 8'h00 : 8'h01);
      for (g = 0; g < 8; g++) begin
        gain_req_i <= g[2:0];
        tick(2);
        e = (m == 0) ? g[2:0] : (m == 2) ? 3'h4 : (g < 2) ? 3'h2 : (g > 3) ? 3'h3 : g[2:0];
        cmp({29'h0, analog_gain_o}, {29'h0, e});
      end
    end
    wr(a(8'h39), 8'h00);
    $display("test gain limits done");
    wr(a(8'h35), 8'h10);
    out_level_i <= 6'h08;
    tick(2);
    cmp({31'h0, over_target_o}, 32'h1);
    tick(4 * FSD);
    cmp({20'h0, clip_atten_o}, 32'h0);
    out_level_i <= 6'h10;
    tick(2);
    cmp({31'h0, over_target_o}, 32'h0);
    for (s = 0; s < 4; s++) begin
      wr(a(8'h38), 8'h80 | s[7:0]);
      rd(a(8'h38), 8'h80 | s[7:0]);
      out_level_i <= 6'h00;
      tick(8 * FSD);
      out_level_i <= 6'h3f;
      tick(2 * FSD + 4);
      a0 = clip_atten_o;
      cmp({31'h0, a0 % (12'h1 << s) == 12'h0 && a0 >= (6 << s) && a0 <= (10 << s)}, 32'h1);
      tick(3 * FSD);
      cmp({20'h0, clip_atten_o}, {20'h0, a0});
      wr(a(8'h38), 8'h00);
      tick(4);
      cmp({20'h0, clip_atten_o}, 32'h0);
    end
    g = 0;
    repeat (4 * FSD) begin
      @(posedge clk_i);
      g += sample_en_o;
    end
    cmp(g, 32'h4);
    $display("test clip guard done");
    r = rnd();
    adc_left_i <= {4'h0, r[15:0]};
    adc_right_i <= 20'h0 - {8'h0, r[27:16]};
    lc = 20'h0 - {4'h0, r[15:0]};
    rc = {8'h0, r[27:16]};
    wr(a(8'h44), 8'h05);
    rd(a(8'h44), 8'h05);
    tick(20 * FSD);
    rd(a(8'h44), 8'h01);
    rd(a(8'h45), lc[15:8]);
    rd(a(8'h46), {4'h0, lc[19:16]});
    rd(a(8'h47), rc[15:8]);
    rd(a(8'h48), {4'h0, rc[19:16]});
    cmp({12'h0, offset_left_o}, {12'h0, lc});
    cmp({12'h0, offset_right_o}, {12'h0, rc});
    wr(a(8'h45), 8'hff);
    adc_left_i <= 20'(rnd());
    tick(4 * FSD);
    rd(a(8'h45), lc[15:8]);
    wr(a(8'h44), 8'h00);
    tick(3);
    cmp({11'h0, offset_en_o, offset_left_o}, 32'h0);
    adc_left_i <= 20'h80000;
    wr(a(8'h44), 8'h04);
    tick(20 * FSD);
    rd(a(8'h44), 8'h08);
    wr(a(8'h44), 8'h00);
    rd(a(8'h44), 8'h08);
    rd(a(8'h47), rc[15:8]);
    $display("test calibration done");
    rd(a(8'h40), 8'h00);
    wr(a(8'h40), 8'h5a);
    rd(a(8'h40), 8'h00);
    cyc(a(8'h37), 1'b1, 8'h11, 4'he);
    rd(a(8'h37), 8'h44);
    rd(32'h000004dc, 8'h00);
    rd(a(8'h3a), 8'h07);
    $display("test bus refusals done");
    conclude();
  end
endmodule
